/* File: design/tdpc_params.svh */
// constants for the tape digit position counter: offsets, fields, reset values, timing
`ifndef TDPC_PARAMS_SVH
`define TDPC_PARAMS_SVH
// ==========================================================
// register byte offsets
`define TDPC_CTRL_OFS 12'h000
`define TDPC_STATUS_OFS 12'h004
`define TDPC_ERRFLAG_OFS 12'h008
`define TDPC_WENDCNT_OFS 12'h00C
// ==========================================================
// control register fields
`define TDPC_CTRL_OP_LSB 0
`define TDPC_CTRL_OP_MSB 1
`define TDPC_CTRL_SOFTCLR_BIT 4
// ==========================================================
// status register fields
`define TDPC_ST_CODE_LSB 0
`define TDPC_ST_CODE_MSB 6
`define TDPC_ST_COUNT_LSB 8
`define TDPC_ST_COUNT_MSB 11
`define TDPC_ST_BUSY_BIT 12
`define TDPC_ST_QERR_BIT 14
`define TDPC_ST_TERR_BIT 15
// ==========================================================
// error flag fields, write one to clear
`define TDPC_EF_RWERR_BIT 0
`define TDPC_EF_DIAG_BIT 1
`define TDPC_EF_REFUSED_BIT 2
// ==========================================================
// reset values and timing
`define TDPC_QUAD_RST 4'h8
`define TDPC_TRI_RST 3'h4
`define TDPC_CLR_DELAY_NS 6000000
`define TDPC_PCLK_NS 20
`define TDPC_CLR_DELAY_CYC ((`TDPC_CLR_DELAY_NS + `TDPC_PCLK_NS - 1) / `TDPC_PCLK_NS)
`endif

/* File: design/tdpc_pkg.sv */
// types for the tape digit position counter
package tdpc_pkg;
  // ==========================================================
  // operation requested by software
  typedef enum logic [1:0] {
    TDPC_OP_NONE = 2'h0,
    TDPC_OP_WRITE = 2'h1,
    TDPC_OP_READ = 2'h2,
    TDPC_OP_CHECK = 2'h3
  } tdpc_op_t;
  // ==========================================================
  // start sequencer, gray coded along idle, armed, timing
  typedef enum logic [1:0] {
    TDPC_SEQ_IDLE = 2'h0,
    TDPC_SEQ_ARMED = 2'h1,
    TDPC_SEQ_TIMING = 2'h3
  } tdpc_seq_t;
endpackage

/* File: design/tdpc_top.sv */
// tape digit position counter with apb register access
//
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "tdpc_params.svh"

// Overview of operation
// - clear pulse resets all seven bits and selects one clear count from mode
// - clear to twelve sets quad bit four and trinary high bit only
// - start clear issues about 6 ms after drive selection fires
// - write start clear only without protected reel and no write running
// - read or check-read start clear only while read-write circuits idle
// - check-read start issues a second clear once numeric mode is set
// - hash pulse at read start or in block separator issues a clear
// - one step per tape cycle in numeric, two in alphanumeric, timed
// - each step raises one step strobe plus quaternary clear strobe
// - plus one and minus three merge into one rotate-up strobe
// - minus one rotates the quaternary bit down, one wraps to four
// - plus one with quad bit four raises carry and advances trinary
// - minus three on bit two or minus one on bit one borrows
// - carry or borrow raises trinary clear strobe before reload
// - numeric forward step from count one asserts word end
// - backward step from count twelve asserts word end
// - alphanumeric forward minus three from count two asserts word end
// - missing quaternary bit or missing trinary bit raises its error
// - both missing-bit checks suppressed while no operation runs
// - either code error sets read-write error and diagnostic flags
// - set gates inhibited by group peers; multiple bits clear to error
// - count held as one-hot quad weights 1-4 plus trinary 0,4,8
// - clear count 12 forward numeric, 11 forward alpha, 1 backward
// - forward alpha plus one then minus three; backward both plus one
module tdpc_top
  import tdpc_pkg::*;
#(
  parameter int CLR_DELAY_CYC = `TDPC_CLR_DELAY_CYC,
  parameter int TMR_W = 20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic numeric_mode,
  input wire logic alphanumeric_mode,
  input wire logic tape_forward,
  input wire logic tape_read_cycle,
  input wire logic tape_write_cycle,
  input wire logic late_sync_pulse,
  input wire logic phase_t1,
  input wire logic phase_t3,
  input wire logic phase_t5,
  input wire logic phase_t7,
  input wire logic drive_select_fired,
  input wire logic write_protected_reel,
  input wire logic write_in_progress,
  input wire logic rw_circuits_available,
  input wire logic hash_pulse_detect,
  input wire logic read_start_window,
  input wire logic block_separator_segment,
  input wire logic check_read_start,
  output logic counter_clear_pulse,
  output logic clear_to_twelve,
  output logic clear_to_eleven,
  output logic clear_to_one,
  output logic step_plus_one,
  output logic step_minus_one,
  output logic step_minus_three,
  output logic combined_rotate_up,
  output logic quaternary_clear_strobe,
  output logic trinary_carry,
  output logic trinary_borrow,
  output logic trinary_clear_strobe,
  output logic word_end,
  output logic [11:0] count_onehot,
  output logic count_is_one,
  output logic count_is_two,
  output logic count_is_twelve,
  output logic [3:0] quad_bits,
  output logic [2:0] tri_bits,
  output logic quaternary_code_error,
  output logic trinary_code_error,
  output logic rw_error_flag,
  output logic diag_error_flag
);

  // ==========================================================
  // helper functions
  function automatic logic is_onehot4(input logic [3:0] v);
    return (v != 4'h0) && ((v & (v - 4'h1)) == 4'h0);
  endfunction

  function automatic logic is_onehot3(input logic [2:0] v);
    return (v != 3'h0) && ((v & (v - 3'h1)) == 3'h0);
  endfunction

  // a bit is set only if its source is the sole bit of the group
  function automatic logic [3:0] quad_up(input logic [3:0] q);
    return is_onehot4(q) ? {q[2:0], q[3]} : 4'h0;
  endfunction

  function automatic logic [3:0] quad_down(input logic [3:0] q);
    return is_onehot4(q) ? {q[0], q[3:1]} : 4'h0;
  endfunction

  function automatic logic [2:0] tri_up(input logic [2:0] t);
    return is_onehot3(t) ? {t[1:0], t[2]} : 3'h0;
  endfunction

  function automatic logic [2:0] tri_down(input logic [2:0] t);
    return is_onehot3(t) ? {t[0], t[2:1]} : 3'h0;
  endfunction

  // count is the sum of trinary weight 0/4/8 and quad weight 1..4
  function automatic logic [3:0] code_to_count(input logic [3:0] q, input logic [2:0] t);
    logic [3:0] qw;
    logic [3:0] tw;
    qw = 4'h0;
    tw = 4'h0;
    if (is_onehot4(q)) begin
      unique case (q)
        4'h1: qw = 4'h1;
        4'h2: qw = 4'h2;
        4'h4: qw = 4'h3;
        default: qw = 4'h4;
      endcase
    end
    if (is_onehot3(t)) begin
      unique case (t)
        3'h1: tw = 4'h0;
        3'h2: tw = 4'h4;
        default: tw = 4'h8;
      endcase
    end
    return (qw == 4'h0 || !is_onehot3(t)) ? 4'h0 : qw + tw;
  endfunction

  // ==========================================================
  // state
  typedef struct packed {
    logic [3:0] quad;
    logic [2:0] tri_;
    tdpc_seq_t seq;
    tdpc_op_t op;
    logic [TMR_W-1:0] timer;
    logic rw_err;
    logic diag_err;
    logic refused;
    logic [7:0] wend_cnt;
    logic [31:0] rdata;
    logic slverr;
  } tdpc_state_t;

  tdpc_state_t st_reg;
  tdpc_state_t st_next;

  // ==========================================================
  // combinational strobes
  logic bus_setup;
  logic bus_access;
  logic wr_ctrl;
  logic wr_err;
  logic soft_clear;
  logic start_expired;
  logic hash_clear;
  logic cycle_any;
  logic late_cycle;
  logic first_step;
  logic second_step;
  logic [3:0] cur_count;
  logic op_running;
  tdpc_op_t req_op;
  logic start_ok;

  assign bus_setup = psel && !penable;
  assign bus_access = psel && penable;
  assign wr_ctrl = bus_access && pwrite && (paddr == `TDPC_CTRL_OFS);
  assign wr_err = bus_access && pwrite && (paddr == `TDPC_ERRFLAG_OFS);
  assign req_op = tdpc_op_t'(pwdata[`TDPC_CTRL_OP_MSB:`TDPC_CTRL_OP_LSB]);
  assign soft_clear = wr_ctrl && pwdata[`TDPC_CTRL_SOFTCLR_BIT];

  // write needs an unprotected reel and no write already going
  always_comb begin
    unique case (req_op)
      TDPC_OP_WRITE: start_ok = !write_protected_reel && !write_in_progress;
      TDPC_OP_READ, TDPC_OP_CHECK: start_ok = rw_circuits_available;
      default: start_ok = 1'b0;
    endcase
  end

  assign start_expired = (st_reg.seq == TDPC_SEQ_TIMING) && (st_reg.timer == '0);
  // noise can fire a read cycle; clearing discards the bogus steps
  assign hash_clear = hash_pulse_detect && (read_start_window || block_separator_segment);
  // check_read_start repeats the clear now that numeric mode is valid
  assign counter_clear_pulse = start_expired || check_read_start || hash_clear
    || soft_clear;

  // one clear count only: backward wins, then alphanumeric, else twelve
  assign clear_to_one = counter_clear_pulse && !tape_forward;
  assign clear_to_eleven = counter_clear_pulse && tape_forward && alphanumeric_mode;
  assign clear_to_twelve = counter_clear_pulse && tape_forward && !alphanumeric_mode;

  // step timing: late sync read cycles step at T7/T1, others at T3/T5
  assign cycle_any = tape_read_cycle || tape_write_cycle;
  assign late_cycle = tape_read_cycle && !tape_write_cycle && late_sync_pulse;
  assign first_step = cycle_any && (late_cycle ? phase_t7 : phase_t3);
  assign second_step = cycle_any && alphanumeric_mode
    && (late_cycle ? phase_t1 : phase_t5);

  // a clear in the same cycle overrides any step
  assign step_minus_one = !counter_clear_pulse && first_step && tape_forward
    && !alphanumeric_mode;
  assign step_plus_one = !counter_clear_pulse
    && ((first_step && (!tape_forward || alphanumeric_mode))
    || (second_step && !tape_forward));
  assign step_minus_three = !counter_clear_pulse && second_step && tape_forward;
  assign combined_rotate_up = step_plus_one || step_minus_three;
  assign quaternary_clear_strobe = combined_rotate_up || step_minus_one;

  assign trinary_carry = step_plus_one && st_reg.quad[3];
  assign trinary_borrow = (step_minus_three && st_reg.quad[1])
    || (step_minus_one && st_reg.quad[0]);
  assign trinary_clear_strobe = trinary_carry || trinary_borrow;

  // ==========================================================
  // decode and word end
  assign cur_count = code_to_count(st_reg.quad, st_reg.tri_);

  genvar gi;
  generate
    for (gi = 0; gi < 12; gi++) begin : g_dec
      assign count_onehot[gi] = (cur_count == 4'(gi + 1));
    end
  endgenerate

  assign count_is_one = count_onehot[0];
  assign count_is_two = count_onehot[1];
  assign count_is_twelve = count_onehot[11];

  assign word_end = (quaternary_clear_strobe && tape_forward && numeric_mode
    && count_is_one)
    || (quaternary_clear_strobe && !tape_forward && count_is_twelve)
    || (step_minus_three && tape_forward && count_is_two);

  // checks only look while an operation holds the circuits
  assign op_running = !rw_circuits_available;
  assign quaternary_code_error = op_running && (st_reg.quad == 4'h0);
  assign trinary_code_error = op_running && (st_reg.tri_ == 3'h0);

  // ==========================================================
  // next state
  always_comb begin
    st_next = st_reg;

    // counter bits
    if (counter_clear_pulse) begin
      if (!tape_forward) begin
        st_next.quad = 4'h1;
        st_next.tri_ = 3'h1;
      end else if (alphanumeric_mode) begin
        st_next.quad = 4'h4;
        st_next.tri_ = 3'h4;
      end else begin
        st_next.quad = `TDPC_QUAD_RST;
        st_next.tri_ = `TDPC_TRI_RST;
      end
    end else if (quaternary_clear_strobe) begin
      st_next.quad = combined_rotate_up ? quad_up(st_reg.quad)
        : quad_down(st_reg.quad);
      if (trinary_clear_strobe) begin
        st_next.tri_ = trinary_carry ? tri_up(st_reg.tri_) : tri_down(st_reg.tri_);
      end
    end

    // start sequencer: arm on accepted request, time from drive firing
    unique case (st_reg.seq)
      TDPC_SEQ_IDLE: begin
        if (wr_ctrl && req_op != TDPC_OP_NONE && start_ok) begin
          st_next.seq = TDPC_SEQ_ARMED;
          st_next.op = req_op;
        end
      end
      TDPC_SEQ_ARMED: begin
        if (drive_select_fired) begin
          st_next.seq = TDPC_SEQ_TIMING;
          st_next.timer = TMR_W'(CLR_DELAY_CYC - 1);
        end
      end
      TDPC_SEQ_TIMING: begin
        if (st_reg.timer == '0) begin
          st_next.seq = TDPC_SEQ_IDLE;
          st_next.op = TDPC_OP_NONE;
        end else begin
          st_next.timer = st_reg.timer - TMR_W'(1);
        end
      end
      default: begin
        st_next.seq = TDPC_SEQ_IDLE;
        st_next.op = TDPC_OP_NONE;
      end
    endcase

    if (word_end) begin
      st_next.wend_cnt = st_reg.wend_cnt + 8'h01;
    end

    // sticky flags: clear by write one, a same-cycle set wins
    if (wr_err) begin
      if (pwdata[`TDPC_EF_RWERR_BIT]) st_next.rw_err = 1'b0;
      if (pwdata[`TDPC_EF_DIAG_BIT]) st_next.diag_err = 1'b0;
      if (pwdata[`TDPC_EF_REFUSED_BIT]) st_next.refused = 1'b0;
    end
    if (quaternary_code_error || trinary_code_error) begin
      st_next.rw_err = 1'b1;
      st_next.diag_err = 1'b1;
    end
    if (wr_ctrl && req_op != TDPC_OP_NONE
        && (!start_ok || st_reg.seq != TDPC_SEQ_IDLE)) begin
      st_next.refused = 1'b1;
    end

    // read data captured in the setup cycle, presented in access
    if (bus_setup) begin
      st_next.slverr = 1'b0;
      st_next.rdata = 32'h0000_0000;
      unique case (paddr)
        `TDPC_CTRL_OFS: begin
          st_next.rdata[`TDPC_CTRL_OP_MSB:`TDPC_CTRL_OP_LSB] = st_reg.op;
        end
        `TDPC_STATUS_OFS: begin
          st_next.rdata[`TDPC_ST_CODE_MSB:`TDPC_ST_CODE_LSB] = {st_reg.tri_, st_reg.quad};
          st_next.rdata[`TDPC_ST_COUNT_MSB:`TDPC_ST_COUNT_LSB] = cur_count;
          st_next.rdata[`TDPC_ST_BUSY_BIT] = (st_reg.seq != TDPC_SEQ_IDLE);
          st_next.rdata[`TDPC_ST_QERR_BIT] = quaternary_code_error;
          st_next.rdata[`TDPC_ST_TERR_BIT] = trinary_code_error;
        end
        `TDPC_ERRFLAG_OFS: begin
          st_next.rdata[`TDPC_EF_RWERR_BIT] = st_reg.rw_err;
          st_next.rdata[`TDPC_EF_DIAG_BIT] = st_reg.diag_err;
          st_next.rdata[`TDPC_EF_REFUSED_BIT] = st_reg.refused;
        end
        `TDPC_WENDCNT_OFS: begin
          st_next.rdata[7:0] = st_reg.wend_cnt;
        end
        default: begin
          st_next.slverr = 1'b1;
        end
      endcase
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg.quad <= `TDPC_QUAD_RST;
      st_reg.tri_ <= `TDPC_TRI_RST;
      st_reg.seq <= TDPC_SEQ_IDLE;
      st_reg.op <= TDPC_OP_NONE;
      st_reg.timer <= '0;
      st_reg.rw_err <= 1'b0;
      st_reg.diag_err <= 1'b0;
      st_reg.refused <= 1'b0;
      st_reg.wend_cnt <= 8'h00;
      st_reg.rdata <= 32'h0000_0000;
      st_reg.slverr <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // outputs
  assign pready = 1'b1;
  assign prdata = bus_access ? st_reg.rdata : 32'h0000_0000;
  assign pslverr = bus_access && st_reg.slverr;
  assign quad_bits = st_reg.quad;
  assign tri_bits = st_reg.tri_;
  assign rw_error_flag = st_reg.rw_err;
  assign diag_error_flag = st_reg.diag_err;

endmodule // tdpc_top

/* File: bench/tdpc_assertions.sv */
// concurrent checks on the digit counter ports
`timescale 1ns/1ps
module tdpc_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic numeric_mode,
  input wire logic tape_forward,
  input wire logic rw_circuits_available,
  input wire logic counter_clear_pulse,
  input wire logic clear_to_twelve,
  input wire logic clear_to_eleven,
  input wire logic clear_to_one,
  input wire logic step_plus_one,
  input wire logic step_minus_one,
  input wire logic step_minus_three,
  input wire logic combined_rotate_up,
  input wire logic quaternary_clear_strobe,
  input wire logic trinary_carry,
  input wire logic trinary_borrow,
  input wire logic trinary_clear_strobe,
  input wire logic word_end,
  input wire logic count_is_one,
  input wire logic count_is_two,
  input wire logic count_is_twelve,
  input wire logic [3:0] quad_bits,
  input wire logic [2:0] tri_bits,
  input wire logic quaternary_code_error,
  input wire logic trinary_code_error,
  input wire logic rw_error_flag,
  input wire logic diag_error_flag
);
  // ==========================================================
  // sequences
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_clear_twelve;
    counter_clear_pulse && clear_to_twelve;
  endsequence
  // clear wins over a step, so steps are only judged in cycles without a clear
  sequence s_step;
    (step_plus_one || step_minus_one || step_minus_three) && !counter_clear_pulse;
  endsequence
  // ==========================================================
  // properties
  a_clear_one_hot: assert property (counter_clear_pulse |->
    $onehot({clear_to_twelve, clear_to_eleven, clear_to_one})) else $error("clear select bad");
  a_clear_code: assert property (s_clear_twelve |=>
    quad_bits == 4'h8 && tri_bits == 3'h4) else $error("clear to twelve code bad");
  a_step_strobe: assert property (s_step |-> quaternary_clear_strobe &&
    $onehot({step_plus_one, step_minus_one, step_minus_three})) else $error("step strobe bad");
  a_merge_up: assert property (combined_rotate_up ==
    (step_plus_one || step_minus_three)) else $error("rotate up strobe bad");
  a_rotate_down: assert property ((s_step ##0 (step_minus_one && $onehot(quad_bits))) |=>
    quad_bits == (($past(quad_bits) >> 1) | ($past(quad_bits) << 3)))
    else $error("rotate down bad");
  a_carry_up: assert property ((s_step ##0 (step_plus_one && quad_bits[3])) |->
    trinary_carry) else $error("carry missing");
  a_borrow_down: assert property ((s_step ##0 ((step_minus_three && quad_bits[1]) ||
    (step_minus_one && quad_bits[0]))) |-> trinary_borrow) else $error("borrow missing");
  a_tri_strobe: assert property ((trinary_carry || trinary_borrow) |->
    trinary_clear_strobe) else $error("trinary strobe missing");
  a_wend_num: assert property ((quaternary_clear_strobe && numeric_mode && tape_forward &&
    count_is_one) |-> word_end) else $error("numeric word end missing");
  a_wend_back: assert property ((quaternary_clear_strobe && !tape_forward &&
    count_is_twelve) |-> word_end) else $error("backward word end missing");
  a_wend_alpha: assert property ((step_minus_three && tape_forward && count_is_two) |->
    word_end) else $error("alphanumeric word end missing");
  a_err_missing: assert property ((!rw_circuits_available && quad_bits == 4'h0) |->
    quaternary_code_error) else $error("quaternary error missing");
  a_err_quiet: assert property (rw_circuits_available |->
    !quaternary_code_error && !trinary_code_error) else $error("error while idle");
  a_err_flags: assert property ((quaternary_code_error || trinary_code_error) |=>
    rw_error_flag && diag_error_flag) else $error("error flags not set");
endmodule // tdpc_assertions

bind tdpc_top tdpc_assertions u_chk (
  .pclk(pclk), .presetn(presetn), .numeric_mode(numeric_mode), .tape_forward(tape_forward),
  .rw_circuits_available(rw_circuits_available), .counter_clear_pulse(counter_clear_pulse),
  .clear_to_twelve(clear_to_twelve), .clear_to_eleven(clear_to_eleven),
  .clear_to_one(clear_to_one), .step_plus_one(step_plus_one), .step_minus_one(step_minus_one),
  .step_minus_three(step_minus_three), .combined_rotate_up(combined_rotate_up),
  .quaternary_clear_strobe(quaternary_clear_strobe), .trinary_carry(trinary_carry),
  .trinary_borrow(trinary_borrow), .trinary_clear_strobe(trinary_clear_strobe),
  .word_end(word_end), .count_is_one(count_is_one), .count_is_two(count_is_two),
  .count_is_twelve(count_is_twelve),
  .quad_bits(quad_bits), .tri_bits(tri_bits), .quaternary_code_error(quaternary_code_error),
  .trinary_code_error(trinary_code_error), .rw_error_flag(rw_error_flag),
  .diag_error_flag(diag_error_flag)
);

/* File: bench/tdpc_tape_model.sv */
// tape cycle timing source and word end consumer standing at the counter's far side
`timescale 1ns/1ps
module tdpc_tape_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire logic [4:0] n_frames,
  input wire logic word_end,
  output logic tape_read_cycle,
  output logic phase_t1,
  output logic phase_t3,
  output logic phase_t5,
  output logic phase_t7,
  output logic busy,
  output logic [4:0] wend_seen
);
  logic [2:0] ph_reg;
  logic [4:0] left_reg;
  // ==========================================================
  // eight-phase tape cycles; nothing moves between runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_reg <= 3'h0;
      left_reg <= 5'h0;
      wend_seen <= 5'h0;
    end else if (go) begin
      ph_reg <= 3'h0;
      left_reg <= n_frames;
      wend_seen <= 5'h0;
    end else if (left_reg != 5'h0) begin
      ph_reg <= ph_reg + 3'h1;
      if (ph_reg == 3'h7) left_reg <= left_reg - 5'h1;
      if (word_end) wend_seen <= wend_seen + 5'h1;
    end
  end
  assign busy = left_reg != 5'h0;
  assign tape_read_cycle = busy;
  assign phase_t1 = busy && ph_reg == 3'h0;
  assign phase_t3 = busy && ph_reg == 3'h2;
  assign phase_t5 = busy && ph_reg == 3'h4;
  assign phase_t7 = busy && ph_reg == 3'h6;
endmodule // tdpc_tape_model

/* File: bench/tape_digit_position_counter_tb.sv */
// self-checking bench for the digit position counter
`timescale 1ns/1ps
module tape_digit_position_counter_tb;
  localparam int CLR = 5;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, e, numeric_mode = 1, alphanumeric_mode = 0, tape_forward = 1;
  logic trc, t1, t3, t5, t7, drive_select_fired = 0, write_protected_reel = 0;
  logic write_in_progress = 0, rw_circuits_available = 1, hash_pulse_detect = 0;
  logic read_start_window = 0, block_separator_segment = 0, check_read_start = 0;
  logic counter_clear_pulse, word_end, go = 0, busy;
  logic [3:0] quad_bits;
  logic [11:0] cnt1h;
  logic [2:0] tri_bits;
  logic [4:0] n_frames = 5'h0, wend_seen;
  int miscompares = 0, n_compared = 0;
  always #10 pclk = ~pclk;
  tdpc_top #(.CLR_DELAY_CYC(CLR)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .numeric_mode(numeric_mode), .alphanumeric_mode(alphanumeric_mode),
    .tape_forward(tape_forward), .tape_read_cycle(trc), .tape_write_cycle(1'b0),
    .late_sync_pulse(1'b0), .phase_t1(t1), .phase_t3(t3), .phase_t5(t5), .phase_t7(t7),
    .drive_select_fired(drive_select_fired), .write_protected_reel(write_protected_reel),
    .write_in_progress(write_in_progress), .rw_circuits_available(rw_circuits_available),
    .hash_pulse_detect(hash_pulse_detect), .read_start_window(read_start_window),
    .block_separator_segment(block_separator_segment), .check_read_start(check_read_start),
    .counter_clear_pulse(counter_clear_pulse), .clear_to_twelve(), .clear_to_eleven(),
    .clear_to_one(), .step_plus_one(), .step_minus_one(), .step_minus_three(),
    .combined_rotate_up(), .quaternary_clear_strobe(), .trinary_carry(), .trinary_borrow(),
    .trinary_clear_strobe(), .word_end(word_end), .count_onehot(cnt1h), .count_is_one(),
    .count_is_two(), .count_is_twelve(), .quad_bits(quad_bits), .tri_bits(tri_bits),
    .quaternary_code_error(), .trinary_code_error(), .rw_error_flag(), .diag_error_flag()
  );
  tdpc_tape_model u_tape (
    .pclk(pclk), .presetn(presetn), .go(go), .n_frames(n_frames), .word_end(word_end),
    .tape_read_cycle(trc), .phase_t1(t1), .phase_t3(t3), .phase_t5(t5), .phase_t7(t7),
    .busy(busy), .wend_seen(wend_seen)
  );
  // ==========================================================
  // helpers
  task end_of_test;
    if (miscompares == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // caller is just past a rising edge; ends one idle cycle after the access
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      miscompares++;
      end_of_test();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // arms a start, fires drive selection, checks the edge count at which the clear shows against exp_k
  task start_op(input logic [1:0] op, input int exp_k);
    int k;
    int seen;
    apb(1'b1, 12'h000, {30'h0, op});
    drive_select_fired <= 1'b1;
    @(posedge pclk);
    drive_select_fired <= 1'b0;
    seen = 0;
    for (k = 1; k <= CLR + 3; k++) begin
      @(posedge pclk);
      if (counter_clear_pulse === 1'b1 && seen == 0) seen = k;
    end
    chk(32'(seen), 32'(exp_k));
  endtask
  task run_mode(input logic num, alp, fwd, input logic [4:0] fr,
                input logic [6:0] clr_code, end_code, input logic [4:0] we);
    int i;
    numeric_mode <= num;
    alphanumeric_mode <= alp;
    tape_forward <= fwd;
    @(posedge pclk);
    apb(1'b1, 12'h000, 32'h0000_0010);
    chk({25'h0, tri_bits, quad_bits}, {25'h0, clr_code});
    n_frames <= fr;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    for (i = 0; i < 400; i++) begin
      @(posedge pclk);
      if (busy === 1'b0) break;
    end
    if (i == 400) begin
      miscompares++;
      end_of_test();
    end
    chk({25'h0, tri_bits, quad_bits}, {25'h0, end_code});
    chk({27'h0, wend_seen}, {27'h0, we});
  endtask
  task pulse_clear(input logic crs, hp, win, sep, exp);
    check_read_start <= crs;
    hash_pulse_detect <= hp;
    read_start_window <= win;
    block_separator_segment <= sep;
    @(posedge pclk);
    chk({31'h0, counter_clear_pulse}, {31'h0, exp});
    check_read_start <= 1'b0;
    hash_pulse_detect <= 1'b0;
    @(posedge pclk);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'h004, 32'h0);
    chk(q, 32'h0000_0C48);
    chk({20'h0, cnt1h}, 32'h0000_0800);
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    tape_forward <= 1'b0;
    start_op(2'h1, CLR);
    chk({25'h0, tri_bits, quad_bits}, 32'h11);
    rw_circuits_available <= 1'b0;
    start_op(2'h2, 0);
    start_op(2'h3, 0);
    rw_circuits_available <= 1'b1;
    write_protected_reel <= 1'b1;
    start_op(2'h1, 0);
    write_protected_reel <= 1'b0;
    write_in_progress <= 1'b1;
    start_op(2'h1, 0);
    write_in_progress <= 1'b0;
    apb(1'b0, 12'h008, 32'h0);
    chk(q, 32'h4);
    apb(1'b1, 12'h008, 32'h4);
    start_op(2'h3, CLR);
    start_op(2'h2, CLR);
    rw_circuits_available <= 1'b0;
    run_mode(1'b1, 1'b0, 1'b1, 5'd12, 7'h48, 7'h48, 5'd1);
    run_mode(1'b1, 1'b0, 1'b1, 5'd1, 7'h48, 7'h44, 5'd0);
    run_mode(1'b0, 1'b1, 1'b1, 5'd6, 7'h44, 7'h44, 5'd1);
    run_mode(1'b0, 1'b1, 1'b1, 5'd1, 7'h44, 7'h41, 5'd0);
    run_mode(1'b1, 1'b0, 1'b0, 5'd12, 7'h11, 7'h11, 5'd1);
    run_mode(1'b0, 1'b1, 1'b0, 5'd1, 7'h11, 7'h14, 5'd0);
    apb(1'b0, 12'h00C, 32'h0);
    chk(q, 32'h3);
    apb(1'b0, 12'h008, 32'h0);
    chk(q, 32'h0);
    pulse_clear(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    pulse_clear(1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
    pulse_clear(1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
    pulse_clear(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    end_of_test();
  end
endmodule // tape_digit_position_counter_tb
